// ==== hdl/pca_regs.sv ====
// Pulse counter auxiliary registers: hold, pending flags, routing, enables
//
// The plain strobed port was chosen for this implementation.
`default_nettype none
// Overview of operation
// - Hold set defers slow-domain transfers
// - Hold clear transfers writes at next tick
// - Per-register pending flags while value crosses
// - Auxiliary count readable in bits 15:0
// - Input one from reflex channel when enabled
// - Input zero from reflex channel when enabled
module pca_regs
	import pca_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire pca_pkg::pca_bus_req_s bus_req,
	output logic [pca_pkg::DATA_W-1:0] rdata,
	input wire logic slow_tick,
	input wire logic [pca_pkg::AUX_W-1:0] auxiliary_count,
	input wire logic [pca_pkg::EVENTS-1:0] event_flags,
	input wire logic [pca_pkg::PIN_LOCS-1:0] pin_zero,
	input wire logic [pca_pkg::PIN_LOCS-1:0] pin_one,
	input wire logic [pca_pkg::REFLEX_CH-1:0] reflex_event_network,
	output logic count_input_zero,
	output logic count_input_one,
	output logic irq,
	output pca_pkg::pca_slow_regs_s slow_regs,
	output logic [pca_pkg::SLOTS-1:0] slow_loaded
);
	import pca_pkg::*;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		addr_hit = (a == off);
	endfunction

	// Codes above the last channel pick nothing
	function automatic logic reflex_pick(input logic [REFLEX_CH-1:0] ch, input logic [SEL_W-1:0] sel);
		reflex_pick = (32'(sel) < REFLEX_CH) ? ch[sel] : 1'b0;
	endfunction

	logic [DATA_W-1:0] int_enable;
	logic [DATA_W-1:0] pin_location;
	logic [DATA_W-1:0] update_hold_control;
	logic [DATA_W-1:0] input_source_select;
	logic [SLOTS-1:0] write_sync_pending;
	logic [DATA_W-1:0] slot_value [SLOTS];

	wire wr = bus_req.wr;
	wire [DATA_W-1:0] wd = bus_req.wdata;
	wire hit_ctrl = addr_hit(bus_req.addr, OFF_CONTROL);
	wire hit_cmd = addr_hit(bus_req.addr, OFF_COMMAND);
	wire hit_top_value_buffer = addr_hit(bus_req.addr, OFF_TOP_BUFFER);
	wire hit_ovs = addr_hit(bus_req.addr, OFF_OVERSAMPLE);
	wire hit_ien = addr_hit(bus_req.addr, OFF_INT_ENABLE);
	wire hit_loc = addr_hit(bus_req.addr, OFF_PIN_LOCATION);
	wire hit_hold = addr_hit(bus_req.addr, OFF_UPDATE_HOLD);
	wire hit_sync = addr_hit(bus_req.addr, OFF_SYNC_PENDING);
	wire hit_aux = addr_hit(bus_req.addr, OFF_AUX_COUNT);
	wire hit_inp = addr_hit(bus_req.addr, OFF_INPUT_SELECT);

	wire [SLOTS-1:0] slot_write = {wr & hit_ovs, wr & hit_top_value_buffer, wr & hit_cmd, wr & hit_ctrl};
	wire [DATA_W-1:0] slot_mask [SLOTS] = '{MASK_CONTROL, MASK_COMMAND, MASK_TOP_BUFFER, MASK_OVERSAMPLE};
	wire update_hold_bit = update_hold_control[HOLD_BIT];

	genvar g;
	generate
		for (g = 0; g < SLOTS; g++) begin : gen_slot
			pca_sync_slot #(
				.RESET_VALUE((g == SLOT_TOP_BUFFER) ? RST_TOP_BUFFER : RST_ZERO)
			) u_slot (
				.clk(clk),
				.rst(rst),
				.write_stb(slot_write[g]),
				.write_value(wd & slot_mask[g]),
				.slow_tick(slow_tick),
				.update_hold_bit(update_hold_bit),
				.pending(write_sync_pending[g]),
				.slow_value(slot_value[g]),
				.loaded(slow_loaded[g])
			);
		end
	endgenerate

	assign slow_regs.control = slot_value[SLOT_CONTROL];
	assign slow_regs.command = slot_value[SLOT_COMMAND];
	assign slow_regs.top_buffer = slot_value[SLOT_TOP_BUFFER];
	assign slow_regs.oversample_config = slot_value[SLOT_OVERSAMPLE];

	// Input routing, reflex channel overrides the routed pin
	wire [LOC_W-1:0] loc_zero = pin_location[LOC_ZERO_LSB +: LOC_W];
	wire [LOC_W-1:0] loc_one = pin_location[LOC_ONE_LSB +: LOC_W];
	wire [SEL_W-1:0] sel_zero = input_source_select[SEL_ZERO_LSB +: SEL_W];
	wire [SEL_W-1:0] sel_one = input_source_select[SEL_ONE_LSB +: SEL_W];
	wire pin_zero_val = (32'(loc_zero) < PIN_LOCS) ? pin_zero[loc_zero[$clog2(PIN_LOCS)-1:0]] : 1'b0;
	wire pin_one_val = (32'(loc_one) < PIN_LOCS) ? pin_one[loc_one[$clog2(PIN_LOCS)-1:0]] : 1'b0;
	wire next_count_input_zero = input_source_select[EN_ZERO_BIT] ?
		reflex_pick(reflex_event_network, sel_zero) : pin_zero_val;
	wire next_count_input_one = input_source_select[EN_ONE_BIT] ?
		reflex_pick(reflex_event_network, sel_one) : pin_one_val;
	wire next_irq = |(event_flags & int_enable[EVENTS-1:0]);

	// Read mux; unmapped and write-only offsets read zero
	wire [DATA_W-1:0] next_rdata =
		hit_ctrl ? slot_value[SLOT_CONTROL] :
		hit_top_value_buffer ? slot_value[SLOT_TOP_BUFFER] :
		hit_ovs ? slot_value[SLOT_OVERSAMPLE] :
		hit_ien ? int_enable :
		hit_loc ? pin_location :
		hit_hold ? update_hold_control :
		hit_sync ? {{(DATA_W-SLOTS){1'b0}}, write_sync_pending} :
		hit_aux ? {{(DATA_W-AUX_W){1'b0}}, auxiliary_count} :
		hit_inp ? input_source_select :
		RST_ZERO;

	always_ff @(posedge clk) begin
		if (rst) begin
			int_enable <= RST_ZERO;
			pin_location <= RST_ZERO;
			update_hold_control <= RST_ZERO;
			input_source_select <= RST_ZERO;
			rdata <= RST_ZERO;
			count_input_zero <= 1'b0;
			count_input_one <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (wr & hit_ien) begin
				int_enable <= wd & MASK_INT_ENABLE;
			end
			if (wr & hit_loc) begin
				pin_location <= wd & MASK_PIN_LOCATION;
			end
			if (wr & hit_hold) begin
				update_hold_control <= wd & MASK_UPDATE_HOLD;
			end
			if (wr & hit_inp) begin
				input_source_select <= wd & MASK_INPUT_SELECT;
			end
			rdata <= bus_req.rd ? next_rdata : RST_ZERO;
			count_input_zero <= next_count_input_zero;
			count_input_one <= next_count_input_one;
			irq <= next_irq;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/pca_pkg.sv ====
// Package for the pulse counter auxiliary register bank
`default_nettype none
package pca_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int SLOTS = 4;
	localparam int REFLEX_CH = 12;
	localparam int PIN_LOCS = 32;

	localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h0_000;
	localparam logic [ADDR_W-1:0] OFF_COMMAND = 12'h0_004;
	localparam logic [ADDR_W-1:0] OFF_TOP_BUFFER = 12'h0_014;
	localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 12'h0_024;
	localparam logic [ADDR_W-1:0] OFF_PIN_LOCATION = 12'h0_02c;
	localparam logic [ADDR_W-1:0] OFF_UPDATE_HOLD = 12'h0_040;
	localparam logic [ADDR_W-1:0] OFF_SYNC_PENDING = 12'h0_044;
	localparam logic [ADDR_W-1:0] OFF_AUX_COUNT = 12'h0_064;
	localparam logic [ADDR_W-1:0] OFF_INPUT_SELECT = 12'h0_068;
	localparam logic [ADDR_W-1:0] OFF_OVERSAMPLE = 12'h0_06c;

	// Pending flag positions, also slot indices
	localparam int SLOT_CONTROL = 0;
	localparam int SLOT_COMMAND = 1;
	localparam int SLOT_TOP_BUFFER = 2;
	localparam int SLOT_OVERSAMPLE = 3;

	localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_TOP_BUFFER = 32'h0000_00ff;

	// Writable masks, reserved bits store nothing
	localparam logic [DATA_W-1:0] MASK_CONTROL = 32'hffff_ffff;
	localparam logic [DATA_W-1:0] MASK_COMMAND = 32'h0000_0003;
	localparam logic [DATA_W-1:0] MASK_TOP_BUFFER = 32'h0000_ffff;
	localparam logic [DATA_W-1:0] MASK_OVERSAMPLE = 32'h0000_10ff;
	localparam logic [DATA_W-1:0] MASK_INT_ENABLE = 32'h0000_003f;
	localparam logic [DATA_W-1:0] MASK_PIN_LOCATION = 32'h0000_3f3f;
	localparam logic [DATA_W-1:0] MASK_UPDATE_HOLD = 32'h0000_0001;
	localparam logic [DATA_W-1:0] MASK_INPUT_SELECT = 32'h0000_0bef;

	// Field positions
	localparam int HOLD_BIT = 0;
	localparam int LOC_ZERO_LSB = 0;
	localparam int LOC_ONE_LSB = 8;
	localparam int LOC_W = 6;
	localparam int SEL_ZERO_LSB = 0;
	localparam int EN_ZERO_BIT = 5;
	localparam int SEL_ONE_LSB = 6;
	localparam int EN_ONE_BIT = 11;
	localparam int SEL_W = 4;
	localparam int AUX_W = 16;
	localparam int EVENTS = 6;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pca_bus_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] control;
		logic [DATA_W-1:0] command;
		logic [DATA_W-1:0] top_buffer;
		logic [DATA_W-1:0] oversample_config;
	} pca_slow_regs_s;
endpackage
`default_nettype wire

// ==== hdl/pca_sync_slot.sv ====
// One register staged for transfer into the slow counter domain
`default_nettype none
module pca_sync_slot #(
	parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic write_stb,
	input wire logic [31:0] write_value,
	input wire logic slow_tick,
	input wire logic update_hold_bit,
	output logic pending,
	output logic [31:0] slow_value,
	output logic loaded
);
	logic [31:0] staged;
	wire transfer = slow_tick & pending & ~update_hold_bit;
	// A write in the transfer cycle keeps the flag up for the new value
	wire next_pending = write_stb | (pending & ~transfer);

	always_ff @(posedge clk) begin
		if (rst) begin
			staged <= RESET_VALUE;
			slow_value <= RESET_VALUE;
			pending <= 1'b0;
			loaded <= 1'b0;
		end else begin
			pending <= next_pending;
			loaded <= transfer;
			if (write_stb) begin
				staged <= write_value;
			end
			if (transfer) begin
				slow_value <= staged;
			end
		end
	end
endmodule
`default_nettype wire

// ==== bench/pca_partner.sv ====
// Far side model: reflex channels, routed pins, auxiliary count
`default_nettype none
module pca_partner
	import pca_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	output logic [pca_pkg::AUX_W-1:0] aux,
	output logic [pca_pkg::REFLEX_CH-1:0] reflex,
	output logic [pca_pkg::PIN_LOCS-1:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// Channels shift every cycle, so a wrong select shows
	always_ff @(posedge clk) begin
		if (rst) begin
			aux <= 16'h0000;
			reflex <= 12'h5a3;
		end else begin
			aux <= aux + 16'h0001;
			reflex <= {reflex[10:0], reflex[11] ^ reflex[4]};
		end
	end
	assign pins = {aux, ~aux};
endmodule
`default_nettype wire

// ==== bench/pca_regs_props.sv ====
// Assertions for the pulse counter auxiliary registers
`default_nettype none
module pca_regs_chk
	import pca_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire pca_pkg::pca_bus_req_s bus_req,
	input wire logic [pca_pkg::DATA_W-1:0] rdata,
	input wire logic slow_tick,
	input wire logic [pca_pkg::AUX_W-1:0] auxiliary_count,
	input wire logic [pca_pkg::EVENTS-1:0] event_flags,
	input wire logic [pca_pkg::REFLEX_CH-1:0] reflex_event_network,
	input wire logic count_input_zero,
	input wire logic count_input_one,
	input wire logic irq,
	input wire pca_pkg::pca_slow_regs_s slow_regs,
	input wire logic [pca_pkg::SLOTS-1:0] slow_loaded
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hold;
	logic [11:0] sel;
	logic [5:0] ien;
	wire w = bus_req.wr;
	wire r = bus_req.rd;
	wire [11:0] a = bus_req.addr;
	// Shadow fields, no peeking inside the design
	always_ff @(posedge clk) begin
		if (rst) begin
			hold <= 1'b0;
			sel <= 12'h000;
			ien <= 6'h00;
		end else if (w) begin
			if (a == OFF_UPDATE_HOLD) hold <= bus_req.wdata[0];
			if (a == OFF_INPUT_SELECT) sel <= bus_req.wdata[11:0] & 12'hbef;
			if (a == OFF_INT_ENABLE) ien <= bus_req.wdata[5:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_hold; slow_loaded != 4'h0 |-> $past(slow_tick && !hold); endproperty
	a_hold: assert property (p_hold) else $error("load while held");
	property p_load; w && a == OFF_CONTROL ##1 !slow_tick ##1 slow_tick && !hold
		|=> slow_loaded[0] && slow_regs.control == $past(bus_req.wdata, 3); endproperty
	a_load: assert property (p_load) else $error("no load at tick");
	property p_pend; w && a == OFF_TOP_BUFFER ##1 !(slow_tick && !hold) ##1 r && a == OFF_SYNC_PENDING
		|=> rdata[2]; endproperty
	a_pend: assert property (p_pend) else $error("pending flag low");
	property p_aux; r && a == OFF_AUX_COUNT |=> rdata == {16'h0000, $past(auxiliary_count)}; endproperty
	a_aux: assert property (p_aux) else $error("aux read wrong");
	property p_one; $past(sel[11]) && $past(sel[9:6]) < 4'hc
		|-> count_input_one == $past(reflex_event_network[sel[9:6]]); endproperty
	a_one: assert property (p_one) else $error("input one route");
	property p_zero; $past(sel[5]) && $past(sel[3:0]) < 4'hc
		|-> count_input_zero == $past(reflex_event_network[sel[3:0]]); endproperty
	a_zero: assert property (p_zero) else $error("input zero route");
	property p_irq; irq == |$past(event_flags & ien); endproperty
	a_irq: assert property (p_irq) else $error("irq wrong");
endmodule
bind pca_regs pca_regs_chk u_chk (
	.clk(clk),
	.rst(rst),
	.bus_req(bus_req),
	.rdata(rdata),
	.slow_tick(slow_tick),
	.auxiliary_count(auxiliary_count),
	.event_flags(event_flags),
	.reflex_event_network(reflex_event_network),
	.count_input_zero(count_input_zero),
	.count_input_one(count_input_one),
	.irq(irq),
	.slow_regs(slow_regs),
	.slow_loaded(slow_loaded)
);
`default_nettype wire

// ==== bench/testbench.sv ====
// Testbench for the pulse counter auxiliary registers
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import pca_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic slow_tick = 1'b0;
	logic [5:0] event_flags = 6'h00;
	pca_bus_req_s bus_req = '0;
	logic [31:0] rdata, d, pins;
	logic [15:0] auxiliary_count;
	logic [11:0] reflex_event_network;
	logic count_input_zero, count_input_one, irq;
	pca_slow_regs_s slow_regs;
	logic [3:0] slow_loaded;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	logic [11:0] offs [6] = '{OFF_INT_ENABLE, OFF_PIN_LOCATION, OFF_INPUT_SELECT, OFF_SYNC_PENDING, 12'hffc,
		OFF_UPDATE_HOLD};
	logic [31:0] wv [6] = '{32'h0000_003f, 32'h0000_3f3f, 32'h0000_0ae3, 32'h0000_000f, 32'h0000_0001, 32'h0000_0001};
	logic [31:0] xv [6] = '{32'h0000_003f, 32'h0000_3f3f, 32'h0000_0ae3, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001};
	initial forever #25 clk = ~clk;
	pca_partner u_far (.clk(clk), .rst(rst), .aux(auxiliary_count), .reflex(reflex_event_network), .pins(pins));
	pca_regs dut (
		.clk(clk),
		.rst(rst),
		.bus_req(bus_req),
		.rdata(rdata),
		.slow_tick(slow_tick),
		.auxiliary_count(auxiliary_count),
		.event_flags(event_flags),
		.pin_zero(pins),
		.pin_one(~pins),
		.reflex_event_network(reflex_event_network),
		.count_input_zero(count_input_zero),
		.count_input_one(count_input_one),
		.irq(irq),
		.slow_regs(slow_regs),
		.slow_loaded(slow_loaded)
	);
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] v);
		bus_req.addr <= ad;
		bus_req.wdata <= v;
		bus_req.wr <= 1'b1;
		@(posedge clk);
		bus_req.wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] ad);
		bus_req.addr <= ad;
		bus_req.rd <= 1'b1;
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic tick();
		slow_tick <= 1'b1;
		@(posedge clk);
		slow_tick <= 1'b0;
		@(posedge clk);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Ceiling well above the 86 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (offs[i]) begin
			rd(offs[i]);
			chk("reset value", d, RST_ZERO);
			wr(offs[i], wv[i]);
			rd(offs[i]);
			chk("readback", d, xv[i]);
		end
		$display("register test done");
		wr(OFF_CONTROL, 32'h1234_5678);
		wr(OFF_TOP_BUFFER, 32'h0000_0abc);
		rd(OFF_SYNC_PENDING);
		chk("pending held", d, 32'h0000_0005);
		tick();
		chk("control held", slow_regs.control, RST_ZERO);
		wr(OFF_UPDATE_HOLD, RST_ZERO);
		tick();
		chk("loaded", {28'h000_0000, slow_loaded}, 32'h0000_0005);
		chk("top buffer", slow_regs.top_buffer, 32'h0000_0abc);
		rd(OFF_SYNC_PENDING);
		chk("pending clear", d, RST_ZERO);
		wr(OFF_CONTROL, 32'ha5a5_0f0f);
		tick();
		chk("control", slow_regs.control, 32'ha5a5_0f0f);
		rd(OFF_AUX_COUNT);
		// Partner has stepped once since the sampling edge
		chk("aux count", d, {16'h0000, auxiliary_count - 16'h0001});
		$display("hold test done");
		event_flags <= 6'h21;
		repeat (2) @(posedge clk);
		chk("irq on", {31'h0, irq}, 32'h0000_0001);
		wr(OFF_INT_ENABLE, 32'h0000_001e);
		@(posedge clk);
		chk("irq masked", {31'h0, irq}, RST_ZERO);
		$display("irq test done");
		wr(OFF_INPUT_SELECT, RST_ZERO);
		wr(OFF_PIN_LOCATION, 32'h0000_1405);
		// Pins as the design samples them on this edge
		d = pins;
		@(posedge clk);
		chk("pin zero", {31'h0, count_input_zero}, {31'h0, d[5]});
		chk("pin one", {31'h0, count_input_one}, {31'h0, ~d[20]});
		wr(OFF_COMMAND, 32'h0000_0003);
		wr(OFF_OVERSAMPLE, 32'h0000_10ab);
		rd(OFF_SYNC_PENDING);
		chk("pending cmd ovs", d, 32'h0000_000a);
		tick();
		chk("loaded cmd ovs", {28'h000_0000, slow_loaded}, 32'h0000_000a);
		chk("command", slow_regs.command, 32'h0000_0003);
		chk("oversample", slow_regs.oversample_config, 32'h0000_10ab);
		$display("routing test done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(OFF_AUX_COUNT);
		chk("aux reset", d, RST_ZERO);
		chk("irq reset", {31'h0, irq}, RST_ZERO);
		rd(OFF_INT_ENABLE);
		chk("enable reset", d, RST_ZERO);
		rd(OFF_UPDATE_HOLD);
		chk("hold reset", d, RST_ZERO);
		$display("reset test done");
		close_out();
	end
endmodule
`default_nettype wire
